//--- sdac_ctrl.sv
`timescale 1ns/10ps
`include "sdac_regs.svh"

// Function
// - Data rate is mclk over N times OVERSAMPLING_RATIO
// - Clock divide field sets master clock
// - Upper clock divide bits read zero
// - Power-off overrides all but reference select, all blocks off
// - Sleep keeps bandgap, amplifier, filter on
// - Normal mode runs modulator and filter
// - Filter reset holds filter, modulator on
// - Conversion starts after reset high-low pulse
// - Done flag set, result overwritten each conversion unless hold set
// - Hold keeps result, later ones still stream out
// - Reference pair select picks internal/external
// - Master clock nominally 4.9152 MHz
// - Results 24-bit two's complement, saturated
// - 10 Hz rate gives mains notch
// - Oversampling code halves 32768 down to 128
// - Filter reset aborts and discards conversion
module sdac_ctrl (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic mod_bit_i,
	output logic [23:0] stream_data_o,
	output logic stream_valid_o,
	input wire logic stream_ready_i,
	output logic mclk_tick_o,
	output logic bandgap_en_o,
	output logic amp_en_o,
	output logic modulator_en_o,
	output logic temp_sensor_en_o,
	output logic ref_buf_n_en_o,
	output logic ref_buf_p_en_o,
	output logic filter_en_o,
	output logic filter_rst_o,
	output logic ref_select_o
);

	sdac_pkg::sdac_ctrl_s st_reg;
	sdac_pkg::sdac_ctrl_s st_next;
	sdac_pkg::sdac_mode_e mode_w;
	logic off_w;
	logic slp_w;
	logic frst_w;
	logic hold_w;
	logic [3:0] osr_code_w;
	logic [3:0] osr_eff_w;
	logic [2:0] flms_w;
	logic [4:0] n_last_w;
	logic [15:0] osr_last_w;
	logic mclk_tick_w;
	logic running_w;
	logic n_end_w;
	logic osr_end_w;
	logic buf_in_ready_w;
	logic conv_end_w;
	logic conv_take_w;
	logic signed [16:0] acc_step_w;
	logic signed [16:0] acc_sum_w;
	logic [23:0] conv_val_w;
	logic temp_sel_w;

	// Saturate a scaled accumulator into 24-bit two's complement
	function automatic logic [23:0] sdac_scale(input logic signed [16:0] acc,
		input logic [3:0] code);
		logic signed [40:0] wide;
		wide = 41'(acc) <<< (`SDAC_RES_SHIFT_BASE + code);
		if (wide > $signed(41'(`SDAC_RES_MAX))) begin
			sdac_scale = `SDAC_RES_MAX;
		end else if (wide < -$signed(41'(`SDAC_RES_MIN))) begin
			sdac_scale = `SDAC_RES_MIN;
		end else begin
			sdac_scale = wide[23:0];
		end
	endfunction : sdac_scale

	sdac_clkdiv u_clkdiv (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.div_i(st_reg.clkdiv[`SDAC_CLKDIV_W-1:0]),
		.tick_o(mclk_tick_w)
	);

	// Result stream buffer; a full buffer stalls the conversion end
	sdac_buf u_buf (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(conv_end_w),
		.in_ready_o(buf_in_ready_w),
		.in_data_i(conv_val_w),
		.out_valid_o(stream_valid_o),
		.out_ready_i(stream_ready_i),
		.out_data_o(stream_data_o)
	);

	assign off_w = st_reg.ctrl0[`SDAC_C0_OFF];
	assign slp_w = st_reg.ctrl0[`SDAC_C0_SLP];
	assign frst_w = st_reg.ctrl0[`SDAC_C0_RST];
	assign hold_w = st_reg.ctrl1[`SDAC_C1_HOLD];
	assign osr_code_w = st_reg.ctrl0[`SDAC_C0_OSR_HI:`SDAC_C0_OSR_LO];
	assign flms_w = st_reg.ctrl1[`SDAC_C1_FLMS_HI:`SDAC_C1_FLMS_LO];

	// power-off wins, then sleep, then filter reset
	always_comb begin
		if (off_w) begin
			mode_w = sdac_pkg::SDAC_PWR_DOWN;
		end else if (slp_w) begin
			mode_w = sdac_pkg::SDAC_SLEEP;
		end else if (frst_w) begin
			mode_w = sdac_pkg::SDAC_FLT_RESET;
		end else begin
			mode_w = sdac_pkg::SDAC_NORMAL;
		end
	end

	// N of 30 with OVERSAMPLING_RATIO code 1 gives notch rate
	// N select; reserved codes fall back to 30
	assign n_last_w = (flms_w == `SDAC_FLMS_N12) ? `SDAC_N12_LAST : `SDAC_N30_LAST;
	// OVERSAMPLING_RATIO by halving; reserved codes act as 128
	assign osr_eff_w = (osr_code_w > `SDAC_OSR_MAX_CODE) ? `SDAC_OSR_MAX_CODE : osr_code_w;
	assign osr_last_w = 16'((17'h1 << (`SDAC_OSR_LOG2_MAX - osr_eff_w)) - 17'h1);

	// conversions only after the start pulse
	assign running_w = st_reg.started && (st_reg.mode == sdac_pkg::SDAC_NORMAL);
	assign n_end_w = mclk_tick_w && (st_reg.n_cnt == n_last_w);
	assign osr_end_w = n_end_w && (st_reg.osr_cnt == osr_last_w);
	assign acc_step_w = mod_bit_i ? 17'sd1 : -17'sd1;
	assign acc_sum_w = st_reg.acc + acc_step_w;
	// one result per N times OVERSAMPLING_RATIO master ticks
	assign conv_end_w = running_w && osr_end_w;
	// flag and latch once, on the accepted word
	assign conv_take_w = conv_end_w && buf_in_ready_w;
	assign conv_val_w = sdac_scale(acc_sum_w, osr_eff_w);
	assign temp_sel_w = (st_reg.chsel[5:3] == `SDAC_CH_TEMP) ||
		(st_reg.chsel[2:0] == `SDAC_CH_TEMP);

	always_comb begin
		st_next = st_reg;
		st_next.mode = mode_w;

		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				`SDAC_OFF_CHSEL: begin
					st_next.chsel = reg_wdata_i[5:0];
				end
				`SDAC_OFF_CTRL0: begin
					st_next.ctrl0 = reg_wdata_i;
				end
				`SDAC_OFF_CTRL1: begin
					// writing one never sets the flag
					st_next.ctrl1 = {reg_wdata_i[7:2],
						reg_wdata_i[1] & st_reg.ctrl1[`SDAC_C1_EOC], 1'b0};
				end
				`SDAC_OFF_CLKDIV: begin
					st_next.clkdiv = {3'h0, reg_wdata_i[4:0]};
				end
				`SDAC_OFF_TRIM: begin
					// stored as written, host keeps pattern
					st_next.trim = reg_wdata_i;
				end
				default: begin
				end
			endcase
		end

		// arm on reset high, start on its fall
		if (off_w) begin
			st_next.armed = 1'b0;
			st_next.started = 1'b0;
		end else if (frst_w) begin
			st_next.armed = 1'b1;
		end else if (st_reg.armed) begin
			st_next.started = 1'b1;
		end

		if (!running_w) begin
			st_next.n_cnt = 5'h00;
			st_next.osr_cnt = 16'h0000;
			st_next.acc = 17'sd0;
		end else if (osr_end_w && !buf_in_ready_w) begin
			// Stall keeps the finished sum until the buffer frees a slot
			st_next.acc = st_reg.acc;
		end else if (mclk_tick_w) begin
			if (n_end_w) begin
				st_next.n_cnt = 5'h00;
				if (osr_end_w) begin
					st_next.osr_cnt = 16'h0000;
					st_next.acc = 17'sd0;
				end else begin
					st_next.osr_cnt = st_reg.osr_cnt + 16'h0001;
					st_next.acc = acc_sum_w;
				end
			end else begin
				st_next.n_cnt = st_reg.n_cnt + 5'h01;
			end
		end

		// set wins over a host clear in the same cycle
		if (conv_take_w) begin
			st_next.ctrl1[`SDAC_C1_EOC] = 1'b1;
			if (!hold_w) begin
				st_next.result = conv_val_w;
			end
		end

		// Registered read data
		if (reg_rd_i) begin
			case (reg_addr_i)
				`SDAC_OFF_CHSEL: st_next.rdata = {2'h0, st_reg.chsel};
				`SDAC_OFF_RES_LO: st_next.rdata = st_reg.result[7:0];
				`SDAC_OFF_RES_MID: st_next.rdata = st_reg.result[15:8];
				`SDAC_OFF_RES_HI: st_next.rdata = st_reg.result[23:16];
				`SDAC_OFF_CTRL0: st_next.rdata = st_reg.ctrl0;
				`SDAC_OFF_CTRL1: st_next.rdata = {st_reg.ctrl1[7:1], 1'b0};
				`SDAC_OFF_CLKDIV: st_next.rdata = {3'h0, st_reg.clkdiv[4:0]};
				`SDAC_OFF_TRIM: st_next.rdata = st_reg.trim;
				default: st_next.rdata = 8'h00;
			endcase
		end

		// Power and analog steering, order: bg amp mod ts bufn bufp flt frst ref
		case (mode_w)
			sdac_pkg::SDAC_PWR_DOWN: begin
				st_next.pwr = 9'h000;
			end
			sdac_pkg::SDAC_SLEEP: begin
				st_next.pwr = {2'b11, 4'b0000, 1'b1, 1'b0, 1'b0};
			end
			sdac_pkg::SDAC_FLT_RESET: begin
				// modulator on, filter held in reset
				st_next.pwr = {3'b111, temp_sel_w, st_reg.ctrl1[`SDAC_C1_BUFN],
					st_reg.ctrl1[`SDAC_C1_BUFP], 2'b11, 1'b0};
			end
			sdac_pkg::SDAC_NORMAL: begin
				// selection bits steer sensor and buffers
				st_next.pwr = {3'b111, temp_sel_w, st_reg.ctrl1[`SDAC_C1_BUFN],
					st_reg.ctrl1[`SDAC_C1_BUFP], 2'b10, 1'b0};
			end
			default: begin
				st_next.pwr = 9'h000;
			end
		endcase
		// reference pair follows its select bit
		st_next.pwr[0] = st_reg.ctrl0[`SDAC_C0_REF];
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.ctrl0 <= `SDAC_RST_CTRL0;
			st_reg.ctrl1 <= `SDAC_RST_CTRL1;
			st_reg.clkdiv <= `SDAC_RST_CLKDIV;
			st_reg.trim <= `SDAC_RST_TRIM;
			st_reg.chsel <= `SDAC_RST_CHSEL;
			st_reg.mode <= sdac_pkg::SDAC_PWR_DOWN;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o = st_reg.rdata;
	// divided master clock as a tick
	assign mclk_tick_o = mclk_tick_w;
	assign bandgap_en_o = st_reg.pwr[8];
	assign amp_en_o = st_reg.pwr[7];
	assign modulator_en_o = st_reg.pwr[6];
	assign temp_sensor_en_o = st_reg.pwr[5];
	assign ref_buf_n_en_o = st_reg.pwr[4];
	assign ref_buf_p_en_o = st_reg.pwr[3];
	assign filter_en_o = st_reg.pwr[2];
	assign filter_rst_o = st_reg.pwr[1];
	assign ref_select_o = st_reg.pwr[0];

endmodule : sdac_ctrl

//--- sdac_regs.svh
`ifndef SDAC_REGS_SVH
`define SDAC_REGS_SVH

// Register offsets
`define SDAC_OFF_CHSEL 8'h03
`define SDAC_OFF_RES_LO 8'h04
`define SDAC_OFF_RES_MID 8'h05
`define SDAC_OFF_RES_HI 8'h06
`define SDAC_OFF_CTRL0 8'h07
`define SDAC_OFF_CTRL1 8'h08
`define SDAC_OFF_CLKDIV 8'h09
`define SDAC_OFF_TRIM 8'h0a

// Reset values
`define SDAC_RST_CHSEL 6'h00
`define SDAC_RST_CTRL0 8'h20
`define SDAC_RST_CTRL1 8'h00
`define SDAC_RST_CLKDIV 8'h00
`define SDAC_RST_TRIM 8'he4

// Control zero fields
`define SDAC_C0_RST 7
`define SDAC_C0_SLP 6
`define SDAC_C0_OFF 5
`define SDAC_C0_OSR_HI 4
`define SDAC_C0_OSR_LO 1
`define SDAC_C0_REF 0

// Control one fields
`define SDAC_C1_FLMS_HI 7
`define SDAC_C1_FLMS_LO 5
`define SDAC_C1_BUFN 4
`define SDAC_C1_BUFP 3
`define SDAC_C1_HOLD 2
`define SDAC_C1_EOC 1

// Clock divide field and channel select
`define SDAC_CLKDIV_W 5
`define SDAC_CLKDIV_BYPASS 5'h1f
`define SDAC_CH_TEMP 3'h7

// Rate settings and result scaling limits
`define SDAC_FLMS_N12 3'h2
`define SDAC_N30_LAST 5'd29
`define SDAC_N12_LAST 5'd11
`define SDAC_OSR_MAX_CODE 4'h8
`define SDAC_OSR_LOG2_MAX 15
`define SDAC_RES_SHIFT_BASE 8
`define SDAC_RES_MAX 24'h7fffff
`define SDAC_RES_MIN 24'h800000

// Nominal master clock target, Hz
`define SDAC_MCLK_TARGET_HZ 4915200

`endif

//--- sdac_pkg.sv
package sdac_pkg;

	typedef enum logic [1:0] {
		SDAC_PWR_DOWN,
		SDAC_SLEEP,
		SDAC_FLT_RESET,
		SDAC_NORMAL
	} sdac_mode_e;

	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} sdac_div_s;

	typedef struct packed {
		logic [23:0] slot0;
		logic [23:0] slot1;
		logic [1:0] count;
	} sdac_buf_s;

	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] clkdiv;
		logic [7:0] trim;
		logic [5:0] chsel;
		logic [23:0] result;
		logic [7:0] rdata;
		logic armed;
		logic started;
		logic [4:0] n_cnt;
		logic [15:0] osr_cnt;
		logic signed [16:0] acc;
		sdac_mode_e mode;
		logic [8:0] pwr;
	} sdac_ctrl_s;

endpackage : sdac_pkg

//--- sdac_clkdiv.sv
`timescale 1ns/10ps
`include "sdac_regs.svh"

module sdac_clkdiv (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] div_i,
	output logic tick_o
);

	sdac_pkg::sdac_div_s st_reg;
	sdac_pkg::sdac_div_s st_next;
	logic [5:0] period_w;

	// Period 2*(n+1) cycles: count 0 .. 2n+1
	assign period_w = {div_i, 1'b1};

	always_comb begin
		st_next = st_reg;
		if (div_i == `SDAC_CLKDIV_BYPASS) begin
			st_next.cnt = 6'h00;
			st_next.tick = 1'b1;
		end else if (st_reg.cnt >= period_w) begin
			st_next.cnt = 6'h00;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 6'h01;
			st_next.tick = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;

endmodule : sdac_clkdiv

//--- sdac_buf.sv
`timescale 1ns/10ps

module sdac_buf (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [23:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [23:0] out_data_o
);

	sdac_pkg::sdac_buf_s st_reg;
	sdac_pkg::sdac_buf_s st_next;
	logic push_w;
	logic pop_w;

	assign in_ready_o = (st_reg.count != 2'd2);
	assign out_valid_o = (st_reg.count != 2'd0);
	assign out_data_o = st_reg.slot0;
	assign push_w = in_valid_i & in_ready_o;
	assign pop_w = out_valid_o & out_ready_i;

	always_comb begin
		st_next = st_reg;
		if (pop_w) begin
			st_next.slot0 = st_reg.slot1;
		end
		if (push_w) begin
			if (st_reg.count == 2'd0 || (st_reg.count == 2'd1 && pop_w)) begin
				st_next.slot0 = in_data_i;
			end else begin
				st_next.slot1 = in_data_i;
			end
		end
		st_next.count = st_reg.count + {1'b0, push_w} - {1'b0, pop_w};
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule : sdac_buf

//--- sdac_ctrl_properties.sv
`timescale 1ns/10ps
module sdac_ctrl_properties (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [23:0] stream_data_o,
	input wire logic stream_valid_o,
	input wire logic stream_ready_i,
	input wire logic bandgap_en_o,
	input wire logic amp_en_o,
	input wire logic modulator_en_o,
	input wire logic temp_sensor_en_o,
	input wire logic ref_buf_n_en_o,
	input wire logic ref_buf_p_en_o,
	input wire logic filter_en_o,
	input wire logic filter_rst_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_off_all_down: assert property (!bandgap_en_o |-> !(amp_en_o | modulator_en_o |
		temp_sensor_en_o | ref_buf_n_en_o | ref_buf_p_en_o | filter_en_o | filter_rst_o))
		else $error("block left on in power down");
	a_sleep_mix: assert property (bandgap_en_o && !modulator_en_o |-> amp_en_o &&
		filter_en_o && !temp_sensor_en_o && !ref_buf_n_en_o && !ref_buf_p_en_o)
		else $error("wrong enables in sleep");
	a_normal_run: assert property (bandgap_en_o && !filter_rst_o && modulator_en_o
		|-> filter_en_o && amp_en_o) else $error("filter off in normal mode");
	a_reset_mod: assert property (filter_rst_o |-> modulator_en_o && bandgap_en_o)
		else $error("modulator off in filter reset");
	a_reset_write: assert property (reg_wr_i && reg_addr_i == 8'h07 |-> ##2
		filter_rst_o == (($past(reg_wdata_i, 2) & 8'he0) == 8'h80))
		else $error("filter reset does not follow control write");
	a_rst_no_word: assert property (filter_rst_o && !stream_valid_o |=> !stream_valid_o)
		else $error("word produced during filter reset");
	a_clkdiv_zero: assert property (reg_rd_i && reg_addr_i == 8'h09 |=>
		reg_rdata_o[7:5] == 3'h0) else $error("upper divide bits not zero");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h0a |=>
		reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_rdata_stands: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without read");
	a_word_stands: assert property (stream_valid_o && !stream_ready_i |=>
		stream_valid_o && $stable(stream_data_o)) else $error("stalled word lost");
endmodule : sdac_ctrl_properties

bind sdac_ctrl sdac_ctrl_properties i_props (.*);

//--- sdac_far_model.sv
`timescale 1ns/10ps
module sdac_far_model (
	input wire logic clk_i,
	input wire logic [1:0] pat_i,
	input wire logic stall_i,
	output logic mod_bit_o,
	output logic ready_o
);
	// Flips once per 12 cycles: with N of 12 at the undivided clock each
	// sample sees the opposite level, so an even sample count sums to zero
	localparam int ALT_SPAN = 12;
	logic alt_reg = 1'b0;
	int alt_cnt_reg = 0;
	always_ff @(posedge clk_i) begin
		if (alt_cnt_reg == ALT_SPAN - 1) begin
			alt_cnt_reg <= 0;
			alt_reg <= ~alt_reg;
		end else begin
			alt_cnt_reg <= alt_cnt_reg + 1;
		end
	end
	assign mod_bit_o = (pat_i == 2'h2) ? alt_reg : pat_i[0];
	assign ready_o = ~stall_i;
endmodule : sdac_far_model

//--- tb_sigma_delta_adc_control.sv
`timescale 1ns/10ps
module tb_sigma_delta_adc_control;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [1:0] pat = 2'h1;
	logic stall = 1'b0;
	logic mod_bit_i, stream_ready_i, stream_valid_o, mclk_tick_o, ref_select_o;
	logic bandgap_en_o, amp_en_o, modulator_en_o, temp_sensor_en_o, filter_en_o;
	logic ref_buf_n_en_o, ref_buf_p_en_o, filter_rst_o;
	logic [7:0] reg_rdata_o;
	logic [23:0] stream_data_o, d;
	logic [8:0] en;
	int errors = 0;
	int n_tests = 0;
	int n;
	assign en = {bandgap_en_o, amp_en_o, modulator_en_o, temp_sensor_en_o, ref_buf_n_en_o,
		ref_buf_p_en_o, filter_en_o, filter_rst_o, ref_select_o};
	sdac_ctrl i_dut (.*);
	sdac_far_model i_far (.clk_i, .pat_i(pat), .stall_i(stall), .mod_bit_o(mod_bit_i),
		.ready_o(stream_ready_i));
	initial forever #5 clk_i = ~clk_i;

	task chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i) #1;
		reg_addr_i = a;
		reg_wdata_i = v;
		reg_wr_i = 1'b1;
		@(posedge clk_i) #1;
		reg_wr_i = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i) #1;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i) #1;
		reg_rd_i = 1'b0;
		chk({16'h0000, reg_rdata_o}, {16'h0000, e});
	endtask : rd

	// Bounded wait for a word; n is 4000 when none came
	task ww;
		n = 0;
		do begin
			@(posedge clk_i) #1;
			n++;
		end while (stream_valid_o !== 1'b1 && n < 4000);
		d = stream_data_o;
	endtask : ww

	task t_regs;
		rd(8'h07, 8'h20);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h0a, 8'he4);
		rd(8'h03, 8'h00);
		rd(8'h40, 8'h00);
		wr(8'h09, 8'hff);
		rd(8'h09, 8'h1f);
		wr(8'h0a, 8'he7);
		rd(8'h0a, 8'he7);
		$display("test regs done");
	endtask : t_regs

	task t_modes;
		logic [7:0] c0[5] = '{8'h20, 8'ha0, 8'h40, 8'h00, 8'h01};
		logic [8:0] ex[5] = '{9'h000, 9'h000, 9'h184, 9'h1fc, 9'h1fd};
		wr(8'h03, 8'h07);
		wr(8'h08, 8'h18);
		for (int i = 0; i < 5; i++) begin
			wr(8'h07, c0[i]);
			repeat (3) @(posedge clk_i);
			#1;
			chk(en, ex[i]);
		end
		wr(8'h07, 8'h80);
		repeat (3) @(posedge clk_i);
		#1;
		chk(en[6], 1'b1);
		chk(en[1], 1'b1);
		wr(8'h03, 8'h00);
		wr(8'h08, 8'h00);
		// Power off clears the arming left by the reset write above
		wr(8'h07, 8'h20);
		$display("test modes done");
	endtask : t_modes

	task t_div;
		logic [7:0] dv[3] = '{8'h00, 8'h02, 8'h1f};
		int ex[3] = '{30, 10, 60};
		wr(8'h07, 8'h10);
		for (int i = 0; i < 3; i++) begin
			wr(8'h09, dv[i]);
			repeat (20) @(posedge clk_i);
			n = 0;
			repeat (60) begin
				@(posedge clk_i) #1;
				n += mclk_tick_o;
			end
			chk(24'(n), 24'(ex[i]));
		end
		$display("test divider done");
	endtask : t_div

	task t_conv;
		wr(8'h08, 8'h40);
		ww;
		chk(24'(n), 24'd4000);
		wr(8'h07, 8'h90);
		wr(8'h07, 8'h10);
		ww;
		chk(d, 24'h7fffff);
		ww;
		chk(24'(n), 24'd1536);
		rd(8'h08, 8'h42);
		wr(8'h08, 8'h40);
		rd(8'h08, 8'h40);
		pat = 2'h0;
		ww;
		ww;
		chk(d, 24'h800000);
		rd(8'h06, 8'h80);
		pat = 2'h2;
		ww;
		ww;
		chk(d, 24'h000000);
		wr(8'h08, 8'h44);
		pat = 2'h1;
		ww;
		ww;
		rd(8'h06, 8'h00);
		wr(8'h08, 8'h40);
		ww;
		rd(8'h06, 8'h7f);
		rd(8'h05, 8'hff);
		repeat (500) @(posedge clk_i);
		wr(8'h07, 8'h90);
		ww;
		chk(24'(n), 24'd4000);
		wr(8'h07, 8'h10);
		ww;
		chk(n inside {[1530:1545]}, 1'b1);
		// Rate changes made just after a word, so no counter overshoots
		wr(8'h07, 8'h0e);
		ww;
		ww;
		chk(24'(n), 24'd3072);
		wr(8'h07, 8'h10);
		wr(8'h08, 8'h00);
		ww;
		ww;
		chk(24'(n), 24'd3840);
		wr(8'h08, 8'h40);
		// Realign to a conversion end for the buffer test
		ww;
		$display("test conversion done");
	endtask : t_conv

	task t_buf;
		@(posedge clk_i) #1;
		stall = 1'b1;
		repeat (4708) @(posedge clk_i);
		#1;
		chk(stream_valid_o, 1'b1);
		chk(stream_data_o, 24'h7fffff);
		stall = 1'b0;
		n = 0;
		// Count pops: valid seen just before each edge with ready high
		repeat (20) begin
			n += stream_valid_o;
			@(posedge clk_i) #1;
		end
		chk(24'(n), 24'd3);
		$display("test buffer done");
	endtask : t_buf

	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (10) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		t_regs;
		t_modes;
		t_div;
		t_conv;
		t_buf;
		wrap_up;
	end

	initial begin
		#1000000;
		errors++;
		wrap_up;
	end
endmodule : tb_sigma_delta_adc_control
